// >>> boot_cfg_regs.svh
// register offsets, write values and reset values of the start-up loader
`ifndef BOOT_CFG_REGS_SVH
`define BOOT_CFG_REGS_SVH

// internal register bus offsets
`define PCS_TX_BUFFER_CTRL_ADDR 16'hD300
`define PCS_RX_BUFFER_CTRL_ADDR 16'hD301
`define TBI_AUTONEG_CTRL_ADDR 16'hD302
`define TBI_PARTNER_STATUS_ADDR 16'hD303
`define GLOBAL_WRED_THRESHOLD_A_ADDR 16'h0400
`define GLOBAL_WRED_THRESHOLD_B_ADDR 16'h0401
`define MAC_CONTROL_FOUR_BASE 16'h0900
`define PORT_BP_THRESHOLD_A_BASE 16'h0A00
`define PORT_BP_THRESHOLD_B_BASE 16'h0A01
`define PORT_STRIDE 16'h0010
`define TAILDROP_THRESHOLD_ONE_ADDR 16'h0B01
`define TAILDROP_THRESHOLD_TWO_ADDR 16'h0B02
`define TAILDROP_THRESHOLD_THREE_ADDR 16'h0B03
`define TAILDROP_THRESHOLD_FOUR_ADDR 16'h0B04
`define QUEUE_RESERVE_BASE 16'h1000
`define QUEUE_WRED_MIN_BASE 16'h1100
`define QUEUE_WRED_MAX_BASE 16'h1200
`define QUEUE_WEIGHT_BASE 16'h1300
`define SWITCH_GLOBAL_CONFIG_ADDR 16'hE000

// values written during self-start
`define PCS_BUFFER_RUN 16'h0001
`define PCS_RX_BUFFER_INIT 16'h0003
`define TBI_AUTONEG_VALUE 16'h00F0
`define TBI_PARTNER_VALUE 16'h0021
`define GLOBAL_WRED_VALUE 16'h0100
`define MAC_CONTROL_FOUR_VALUE 16'h1494
`define PORT_BP_A_VALUE 16'h0018
`define PORT_BP_B_VALUE 16'h001E
`define TAILDROP_VALUE 16'h03FF
`define QUEUE_RESERVE_VALUE 16'h001E
`define QUEUE_WRED_VALUE 16'h03FF
`define QUEUE_WEIGHT_VALUE 16'hFFFF
`define SWITCH_ENABLE_VALUE 16'h8000

// memory probe
`define PROBE_LAST_ADDR 8'h05
`define CONFIRM_ADDR 8'h06
`define DIVIDER_ADDR 8'h07
`define CONFIRM_VALUE 8'hAA
`define ID_PATTERN 16'h5454
`define ID_MASK 16'hFCFC

// spi master reset values
`define ADDR_MODE_RESET 2'h2
`define SPI_SPI_CLOCK_DIVIDER_RESET 8'hFF

// strap synchroniser: edges until all three stages hold the pin level
`define STRAP_SETTLE_COUNT 2'h3

`endif

// >>> boot_cfg_pkg.sv
// types of the start-up configuration loader
package boot_cfg_pkg;

  typedef enum logic [3:0] {
    ST_STRAP = 4'h0,
    ST_WRITE = 4'h1,
    ST_WAIT_ACK = 4'h2,
    ST_READ = 4'h3,
    ST_READ_WAIT = 4'h4,
    ST_CHECK = 4'h5,
    ST_CONFIRM = 4'h6,
    ST_LOAD = 4'h7,
    ST_SKIP = 4'h8,
    ST_DONE = 4'h9
  } state_t;

  typedef enum logic [4:0] {
    SQ_TXB_RUN = 5'h00,
    SQ_RXB_INIT = 5'h01,
    SQ_RXB_RUN = 5'h02,
    SQ_ANEG = 5'h03,
    SQ_PARTNER = 5'h04,
    SQ_WRED_A = 5'h05,
    SQ_WRED_B = 5'h06,
    SQ_MAC4 = 5'h07,
    SQ_BP_A = 5'h08,
    SQ_BP_B = 5'h09,
    SQ_TD1 = 5'h0A,
    SQ_TD2 = 5'h0B,
    SQ_TD3 = 5'h0C,
    SQ_TD4 = 5'h0D,
    SQ_Q_RES = 5'h0E,
    SQ_Q_WMIN = 5'h0F,
    SQ_Q_WMAX = 5'h10,
    SQ_Q_WEIGHT = 5'h11,
    SQ_GCFG = 5'h12
  } step_t;

  typedef enum logic [1:0] {
    AM_9BIT = 2'h0,
    AM_16BIT = 2'h1,
    AM_24BIT = 2'h2,
    AM_24BIT_HS = 2'h3
  } addr_mode_t;

endpackage : boot_cfg_pkg

// >>> boot_config_eeprom_detect.sv
// start-up loader: with the no-wait strap, self-start register writes, then memory detection; without it, memory detection only
//
// Summary of operation
// R01: write 0001h to run PCS transmit buffer
// R02: receive buffer: write 0003h, then 0001h
// R03: autoneg 00F0h, then partner status 0021h
// R04: both global WRED thresholds get 0100h
// R05: every port MAC control four gets 1494h
// R06: per-port backpressure thresholds 0018h and 001Eh
// R07: four tail-drop thresholds all get 03FFh
// R08: every queue reservation gets 001Eh
// R09: every queue WRED green min/max 03FFh
// R10: every queue weight FFFFh, strict priority
// R11: finally write 8000h to global config
// R12: no-wait strap: self-start first, then probe
// R13: probe starts manual, low speed, 24-bit
// R14: read first six memory bytes
// R15: receive word 010101XX010101XX means probably present
// R16: copy low two bits into address mode
// R17: with new mode read addresses 6, 7
// R18: confirmed only when address 6 is AAh
// R19: load clock divider from address 7
// R20: after divider set, start record loading
// R21: mode 00 9-bit,01 16-bit,10/11 24-bit
// R22: failed check skips memory, keeps self-start
`timescale 1ns/10ps
`default_nettype none
`include "boot_cfg_regs.svh"

module boot_config_eeprom_detect #(
  parameter int N_PORTS = 5,
  parameter int N_QUEUES = 32
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // strap pin
  input wire logic no_wait_strap,
  // internal register bus master
  output logic reg_wr_req,
  output logic [15:0] reg_addr,
  output logic [15:0] reg_wdata,
  input wire logic reg_wr_ack,
  // spi master byte read port
  output logic spi_rd_req,
  output logic [7:0] spi_rd_addr,
  input wire logic spi_rd_valid,
  input wire logic [7:0] spi_rd_data,
  // spi master configuration
  output logic spi_manual_mode,
  output logic [1:0] memory_address_mode,
  output logic [7:0] spi_clock_divider,
  // status
  output logic selfstart_done,
  output logic eeprom_detected,
  output logic load_start,
  output logic boot_done
);

  if (N_PORTS < 1 || N_PORTS > 256
      || N_QUEUES < 1 || N_QUEUES > 256) begin : g_count_check
    $error("port and queue counts must lie in 1..256");
  end

  boot_cfg_pkg::state_t state;
  boot_cfg_pkg::step_t step;
  logic [7:0] idx;
  logic strap_s1;
  logic strap_s2;
  logic strap_s3;
  logic [1:0] strap_fill;
  logic strap_ready;
  logic no_wait;
  logic [15:0] spi_master_rx_word;
  logic [7:0] confirm_byte;
  logic [7:0] divider_byte;
  logic id_match;
  logic [7:0] last_idx;

  // address and data of one self-start write
  function automatic logic [31:0] seq_entry(
    input boot_cfg_pkg::step_t s,
    input logic [7:0] i
  );
    logic [15:0] po;
    logic [15:0] qo;
    po = 16'({8'h00, i} * `PORT_STRIDE);
    qo = {8'h00, i};
    case (s)
      boot_cfg_pkg::SQ_TXB_RUN:
        seq_entry = {`PCS_TX_BUFFER_CTRL_ADDR, `PCS_BUFFER_RUN};
      boot_cfg_pkg::SQ_RXB_INIT:
        seq_entry = {`PCS_RX_BUFFER_CTRL_ADDR, `PCS_RX_BUFFER_INIT};
      boot_cfg_pkg::SQ_RXB_RUN:
        seq_entry = {`PCS_RX_BUFFER_CTRL_ADDR, `PCS_BUFFER_RUN};
      boot_cfg_pkg::SQ_ANEG:
        seq_entry = {`TBI_AUTONEG_CTRL_ADDR, `TBI_AUTONEG_VALUE};
      boot_cfg_pkg::SQ_PARTNER:
        seq_entry = {`TBI_PARTNER_STATUS_ADDR, `TBI_PARTNER_VALUE};
      boot_cfg_pkg::SQ_WRED_A:
        seq_entry = {`GLOBAL_WRED_THRESHOLD_A_ADDR, `GLOBAL_WRED_VALUE};
      boot_cfg_pkg::SQ_WRED_B:
        seq_entry = {`GLOBAL_WRED_THRESHOLD_B_ADDR, `GLOBAL_WRED_VALUE};
      boot_cfg_pkg::SQ_MAC4:
        seq_entry = {16'(`MAC_CONTROL_FOUR_BASE + po), `MAC_CONTROL_FOUR_VALUE};
      boot_cfg_pkg::SQ_BP_A:
        seq_entry = {16'(`PORT_BP_THRESHOLD_A_BASE + po), `PORT_BP_A_VALUE};
      boot_cfg_pkg::SQ_BP_B:
        seq_entry = {16'(`PORT_BP_THRESHOLD_B_BASE + po), `PORT_BP_B_VALUE};
      boot_cfg_pkg::SQ_TD1:
        seq_entry = {`TAILDROP_THRESHOLD_ONE_ADDR, `TAILDROP_VALUE};
      boot_cfg_pkg::SQ_TD2:
        seq_entry = {`TAILDROP_THRESHOLD_TWO_ADDR, `TAILDROP_VALUE};
      boot_cfg_pkg::SQ_TD3:
        seq_entry = {`TAILDROP_THRESHOLD_THREE_ADDR, `TAILDROP_VALUE};
      boot_cfg_pkg::SQ_TD4:
        seq_entry = {`TAILDROP_THRESHOLD_FOUR_ADDR, `TAILDROP_VALUE};
      boot_cfg_pkg::SQ_Q_RES:
        seq_entry = {16'(`QUEUE_RESERVE_BASE + qo), `QUEUE_RESERVE_VALUE};
      boot_cfg_pkg::SQ_Q_WMIN:
        seq_entry = {16'(`QUEUE_WRED_MIN_BASE + qo), `QUEUE_WRED_VALUE};
      boot_cfg_pkg::SQ_Q_WMAX:
        seq_entry = {16'(`QUEUE_WRED_MAX_BASE + qo), `QUEUE_WRED_VALUE};
      boot_cfg_pkg::SQ_Q_WEIGHT:
        seq_entry = {16'(`QUEUE_WEIGHT_BASE + qo), `QUEUE_WEIGHT_VALUE};
      boot_cfg_pkg::SQ_GCFG:
        seq_entry = {`SWITCH_GLOBAL_CONFIG_ADDR, `SWITCH_ENABLE_VALUE};
      default:
        seq_entry = {`SWITCH_GLOBAL_CONFIG_ADDR, `SWITCH_ENABLE_VALUE};
    endcase
  endfunction : seq_entry

  // last index of a step that repeats per port or per queue
  function automatic logic [7:0] step_last(input boot_cfg_pkg::step_t s);
    case (s)
      boot_cfg_pkg::SQ_MAC4, boot_cfg_pkg::SQ_BP_A, boot_cfg_pkg::SQ_BP_B:
        step_last = 8'(N_PORTS - 1);
      boot_cfg_pkg::SQ_Q_RES, boot_cfg_pkg::SQ_Q_WMIN,
      boot_cfg_pkg::SQ_Q_WMAX, boot_cfg_pkg::SQ_Q_WEIGHT:
        step_last = 8'(N_QUEUES - 1);
      default:
        step_last = 8'h00;
    endcase
  endfunction : step_last

  assign last_idx = step_last(step);
  // don't-care bits masked off
  assign id_match = (spi_master_rx_word & `ID_MASK) == `ID_PATTERN; // R15

  // strap pin: three stages, the level counts once stages two and three agree
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      strap_s1 <= 1'b0;
      strap_s2 <= 1'b0;
      strap_s3 <= 1'b0;
      strap_fill <= 2'h0;
    end else begin
      strap_s1 <= no_wait_strap;
      strap_s2 <= strap_s1;
      strap_s3 <= strap_s2;
      if (strap_fill != `STRAP_SETTLE_COUNT) begin
        strap_fill <= 2'(strap_fill + 2'h1);
      end
    end
  end

  // sampled once after reset; later strap changes are ignored
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      strap_ready <= 1'b0;
      no_wait <= 1'b0;
    end else if (!strap_ready && strap_fill == `STRAP_SETTLE_COUNT
                 && strap_s2 == strap_s3) begin
      strap_ready <= 1'b1;
      no_wait <= strap_s3;
    end
  end

  // sequencer, register bus writes and memory read requests
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= boot_cfg_pkg::ST_STRAP;
      step <= boot_cfg_pkg::SQ_TXB_RUN;
      idx <= 8'h00;
      reg_wr_req <= 1'b0;
      reg_addr <= 16'h0000;
      reg_wdata <= 16'h0000;
      spi_rd_req <= 1'b0;
      spi_rd_addr <= 8'h00;
      selfstart_done <= 1'b0;
      load_start <= 1'b0;
      boot_done <= 1'b0;
    end else begin
      load_start <= 1'b0;
      case (state)
        boot_cfg_pkg::ST_STRAP: begin
          if (strap_ready) begin
            // without the strap the probe starts at once
            state <= no_wait ? boot_cfg_pkg::ST_WRITE
                             : boot_cfg_pkg::ST_READ; // R12
          end
        end
        boot_cfg_pkg::ST_WRITE: begin
          {reg_addr, reg_wdata} <= seq_entry(step, idx); // R01 R02 R03 R04
          reg_wr_req <= 1'b1;
          state <= boot_cfg_pkg::ST_WAIT_ACK;
        end
        boot_cfg_pkg::ST_WAIT_ACK: begin
          if (reg_wr_ack) begin
            reg_wr_req <= 1'b0;
            if (step == boot_cfg_pkg::SQ_GCFG) begin
              selfstart_done <= 1'b1; // R11
              state <= boot_cfg_pkg::ST_READ; // R12
            end else if (idx != last_idx) begin
              idx <= 8'(idx + 8'h01); // R05 R06 R08 R09 R10
              state <= boot_cfg_pkg::ST_WRITE;
            end else begin
              idx <= 8'h00;
              step <= boot_cfg_pkg::step_t'(5'(step + 5'h01)); // R07
              state <= boot_cfg_pkg::ST_WRITE;
            end
          end
        end
        boot_cfg_pkg::ST_READ: begin
          spi_rd_req <= 1'b1;
          state <= boot_cfg_pkg::ST_READ_WAIT;
        end
        boot_cfg_pkg::ST_READ_WAIT: begin
          if (spi_rd_valid) begin
            spi_rd_req <= 1'b0;
            if (spi_rd_addr == `PROBE_LAST_ADDR) begin
              state <= boot_cfg_pkg::ST_CHECK; // R14
            end else if (spi_rd_addr == `DIVIDER_ADDR) begin
              state <= boot_cfg_pkg::ST_CONFIRM;
            end else begin
              spi_rd_addr <= 8'(spi_rd_addr + 8'h01);
              state <= boot_cfg_pkg::ST_READ;
            end
          end
        end
        boot_cfg_pkg::ST_CHECK: begin
          if (id_match) begin
            spi_rd_addr <= `CONFIRM_ADDR; // R17
            state <= boot_cfg_pkg::ST_READ;
          end else begin
            state <= boot_cfg_pkg::ST_SKIP; // R22
          end
        end
        boot_cfg_pkg::ST_CONFIRM: begin
          state <= (confirm_byte == `CONFIRM_VALUE)
                   ? boot_cfg_pkg::ST_LOAD : boot_cfg_pkg::ST_SKIP; // R18 R22
        end
        boot_cfg_pkg::ST_LOAD: begin
          load_start <= 1'b1; // R20
          boot_done <= 1'b1;
          state <= boot_cfg_pkg::ST_DONE;
        end
        boot_cfg_pkg::ST_SKIP: begin
          boot_done <= 1'b1;
          state <= boot_cfg_pkg::ST_DONE;
        end
        boot_cfg_pkg::ST_DONE: begin
          state <= boot_cfg_pkg::ST_DONE;
        end
        default: begin
          state <= boot_cfg_pkg::ST_DONE;
        end
      endcase
    end
  end

  // captured memory bytes and spi master configuration
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      spi_master_rx_word <= 16'h0000;
      confirm_byte <= 8'h00;
      divider_byte <= 8'h00;
      spi_manual_mode <= 1'b1; // R13
      memory_address_mode <= `ADDR_MODE_RESET; // R13 R21
      spi_clock_divider <= `SPI_SPI_CLOCK_DIVIDER_RESET; // R13
      eeprom_detected <= 1'b0;
    end else begin
      if (state == boot_cfg_pkg::ST_READ_WAIT && spi_rd_valid) begin
        case (spi_rd_addr)
          8'h00: spi_master_rx_word[15:8] <= spi_rd_data;
          8'h01: spi_master_rx_word[7:0] <= spi_rd_data;
          `CONFIRM_ADDR: confirm_byte <= spi_rd_data;
          `DIVIDER_ADDR: divider_byte <= spi_rd_data;
          default: confirm_byte <= confirm_byte;
        endcase
      end
      if (state == boot_cfg_pkg::ST_CHECK && id_match) begin
        memory_address_mode <= spi_master_rx_word[1:0]; // R16 R21
      end
      if (state == boot_cfg_pkg::ST_CONFIRM && confirm_byte == `CONFIRM_VALUE) begin
        spi_clock_divider <= divider_byte; // R19
        eeprom_detected <= 1'b1; // R18
        // record loading runs on the configured divider, not manual mode
        spi_manual_mode <= 1'b0;
      end
    end
  end

  // assertions
  sequence s_rx_init_acked;
    reg_wr_req && reg_wr_ack && reg_addr == `PCS_RX_BUFFER_CTRL_ADDR
      && reg_wdata == `PCS_RX_BUFFER_INIT;
  endsequence

  sequence s_rx_run_issued;
    ##[1:4] (reg_wr_req && reg_addr == `PCS_RX_BUFFER_CTRL_ADDR
      && reg_wdata == `PCS_BUFFER_RUN);
  endsequence

  a_txb_run_value: assert property (@(posedge clk_sys) disable iff (!rst_n) // R01
    reg_wr_req && reg_addr == `PCS_TX_BUFFER_CTRL_ADDR
      |-> reg_wdata == `PCS_BUFFER_RUN)
    else $error("transmit buffer written with wrong value");

  a_rxb_init_run: assert property (@(posedge clk_sys) disable iff (!rst_n) // R02
    s_rx_init_acked |-> s_rx_run_issued)
    else $error("receive buffer run write did not follow init");

  a_partner_value: assert property (@(posedge clk_sys) disable iff (!rst_n) // R03
    reg_wr_req && reg_addr == `TBI_PARTNER_STATUS_ADDR
      |-> reg_wdata == `TBI_PARTNER_VALUE)
    else $error("partner status written with wrong value");

  a_write_held: assert property (@(posedge clk_sys) disable iff (!rst_n) // write request, address and data held until acknowledged
    reg_wr_req && !reg_wr_ack |=> reg_wr_req && $stable(reg_addr)
      && $stable(reg_wdata))
    else $error("register write dropped before acknowledge");

  a_enable_last: assert property (@(posedge clk_sys) disable iff (!rst_n) // R11
    reg_wr_req && reg_wr_ack && reg_addr == `SWITCH_GLOBAL_CONFIG_ADDR
      |=> selfstart_done && !reg_wr_req ##1 spi_rd_req)
    else $error("probe did not follow switch enable");

  a_probe_after: assert property (@(posedge clk_sys) disable iff (!rst_n) // R12
    spi_rd_req && no_wait |-> selfstart_done)
    else $error("memory probed before self-start finished");

  a_probe_mode: assert property (@(posedge clk_sys) disable iff (!rst_n) // R13
    spi_rd_req && spi_rd_addr <= `PROBE_LAST_ADDR
      |-> spi_manual_mode && memory_address_mode == `ADDR_MODE_RESET
        && spi_clock_divider == `SPI_SPI_CLOCK_DIVIDER_RESET)
    else $error("probe not in manual 24-bit low speed mode");

  a_mode_copy: assert property (@(posedge clk_sys) disable iff (!rst_n) // R16
    state == boot_cfg_pkg::ST_CHECK && id_match
      |=> memory_address_mode == $past(spi_master_rx_word[1:0])
        ##1 spi_rd_req && spi_rd_addr == `CONFIRM_ADDR)
    else $error("address mode not taken from receive word");

  a_no_match_skip: assert property (@(posedge clk_sys) disable iff (!rst_n) // R22
    state == boot_cfg_pkg::ST_CHECK && !id_match
      |=> ##1 boot_done && !eeprom_detected && !load_start)
    else $error("failed pattern did not skip loading");

  a_divider_load: assert property (@(posedge clk_sys) disable iff (!rst_n) // R19
    $rose(load_start) |-> eeprom_detected && spi_clock_divider == divider_byte
      && confirm_byte == `CONFIRM_VALUE)
    else $error("loading started without confirmed divider");

endmodule : boot_config_eeprom_detect

`default_nettype wire

// >>> eeprom_model.sv
// behavioural serial configuration memory answering byte reads
`timescale 1ns/10ps
`default_nettype none

module eeprom_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // byte read port
  input wire logic spi_rd_req,
  input wire logic [7:0] spi_rd_addr,
  output logic spi_rd_valid,
  output logic [7:0] spi_rd_data,
  // memory image, byte n at bits 8n+7 down to 8n
  input wire logic [63:0] image
);
  logic busy;
  logic [2:0] wait_cnt;

  // latency follows the address so prompt and slow answers both occur
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy <= #1 1'h0;
      wait_cnt <= #1 3'h0;
      spi_rd_valid <= #1 1'h0;
      spi_rd_data <= #1 8'h5A;
    end else if (spi_rd_valid) begin
      busy <= #1 1'h0;
      spi_rd_valid <= #1 1'h0;
      // line no longer held: never leave the last byte standing
      spi_rd_data <= #1 ~spi_rd_data;
    end else if (spi_rd_req && !busy) begin
      busy <= #1 1'h1;
      wait_cnt <= #1 {spi_rd_addr[1:0], 1'h0};
    end else if (busy && wait_cnt == 3'h0) begin
      spi_rd_valid <= #1 1'h1;
      spi_rd_data <= #1 image[8 * spi_rd_addr[2:0] +: 8];
    end else if (busy) begin
      wait_cnt <= #1 wait_cnt - 3'h1;
    end
  end
endmodule : eeprom_model

`default_nettype wire

// >>> tb_boot_config_eeprom_detect.sv
// testbench of the start-up loader with a memory model
`timescale 1ns/10ps
`default_nettype none
`include "boot_cfg_regs.svh"

module tb_boot_config_eeprom_detect;
  typedef struct {
    logic strap;
    logic [63:0] img;
    logic m;
    logic d;
    logic [1:0] mode;
  } row_t;

  logic clk_sys = 1'h0;
  logic rst_n = 1'h0;
  logic no_wait_strap = 1'h1;
  logic reg_wr_req, reg_wr_ack = 1'h0, spi_rd_req, spi_rd_valid;
  logic [15:0] reg_addr, reg_wdata;
  logic [7:0] spi_rd_addr, spi_rd_data, spi_clock_divider;
  logic spi_manual_mode, selfstart_done, eeprom_detected;
  logic load_start, boot_done;
  logic [1:0] memory_address_mode, exp_mode;
  logic [63:0] img = 64'h0;
  logic [31:0] wq[$];
  logic [7:0] rq[$];
  int err_count = 0;
  int check_count = 0;
  int ld_cnt, ack_wait = 0, ack_gap = 0;
  row_t rows[6] = '{
    '{1'h1, 64'h3CAA_5454_5454_5655, 1'h1, 1'h1, 2'h2},
    '{1'h1, 64'h07AA_5454_5454_5555, 1'h1, 1'h1, 2'h1},
    '{1'h1, 64'h07AB_5454_5454_5455, 1'h1, 1'h0, 2'h0},
    '{1'h1, 64'h00AA_5454_5454_5757, 1'h1, 1'h1, 2'h3},
    '{1'h1, 64'h07AA_5454_5454_55D5, 1'h0, 1'h0, 2'h2},
    '{1'h0, 64'h11AA_5454_5454_5055, 1'h0, 1'h0, 2'h2}};

  always #12.5 clk_sys = ~clk_sys;

  boot_config_eeprom_detect #(.N_PORTS(2), .N_QUEUES(2)) u_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .no_wait_strap(no_wait_strap),
    .reg_wr_req(reg_wr_req), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr_ack(reg_wr_ack), .spi_rd_req(spi_rd_req),
    .spi_rd_addr(spi_rd_addr), .spi_rd_valid(spi_rd_valid),
    .spi_rd_data(spi_rd_data), .spi_manual_mode(spi_manual_mode),
    .memory_address_mode(memory_address_mode),
    .spi_clock_divider(spi_clock_divider),
    .selfstart_done(selfstart_done), .eeprom_detected(eeprom_detected),
    .load_start(load_start), .boot_done(boot_done));

  eeprom_model u_mem (
    .clk_sys(clk_sys), .rst_n(rst_n), .spi_rd_req(spi_rd_req),
    .spi_rd_addr(spi_rd_addr), .spi_rd_valid(spi_rd_valid),
    .spi_rd_data(spi_rd_data), .image(img));

  task automatic check(input string name, input logic [31:0] e,
                       input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, e, g);
    end
  endtask : check

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic build(input row_t r);
    wq.delete();
    rq.delete();
    if (r.strap) begin
      wq.push_back({`PCS_TX_BUFFER_CTRL_ADDR, 16'h0001});
      wq.push_back({`PCS_RX_BUFFER_CTRL_ADDR, 16'h0003});
      wq.push_back({`PCS_RX_BUFFER_CTRL_ADDR, 16'h0001});
      wq.push_back({`TBI_AUTONEG_CTRL_ADDR, 16'h00F0});
      wq.push_back({`TBI_PARTNER_STATUS_ADDR, 16'h0021});
      wq.push_back({`GLOBAL_WRED_THRESHOLD_A_ADDR, 16'h0100});
      wq.push_back({`GLOBAL_WRED_THRESHOLD_B_ADDR, 16'h0100});
      for (int p = 0; p < 2; p++) begin
        wq.push_back({`MAC_CONTROL_FOUR_BASE + 16'(p) * `PORT_STRIDE,
                      16'h1494});
      end
      for (int p = 0; p < 2; p++) begin
        wq.push_back({`PORT_BP_THRESHOLD_A_BASE + 16'(p) * `PORT_STRIDE,
                      16'h0018});
      end
      for (int p = 0; p < 2; p++) begin
        wq.push_back({`PORT_BP_THRESHOLD_B_BASE + 16'(p) * `PORT_STRIDE,
                      16'h001E});
      end
      for (int t = 1; t < 5; t++) begin
        wq.push_back({16'h0B00 + 16'(t), 16'h03FF});
      end
      for (int q = 0; q < 2; q++) begin
        wq.push_back({`QUEUE_RESERVE_BASE + 16'(q), 16'h001E});
      end
      for (int q = 0; q < 2; q++) begin
        wq.push_back({`QUEUE_WRED_MIN_BASE + 16'(q), 16'h03FF});
      end
      for (int q = 0; q < 2; q++) begin
        wq.push_back({`QUEUE_WRED_MAX_BASE + 16'(q), 16'h03FF});
      end
      for (int q = 0; q < 2; q++) begin
        wq.push_back({`QUEUE_WEIGHT_BASE + 16'(q), 16'hFFFF});
      end
      wq.push_back({`SWITCH_GLOBAL_CONFIG_ADDR, 16'h8000});
    end
    for (int a = 0; a < 6; a++) begin
      rq.push_back(8'(a));
    end
    if (r.m) begin
      rq.push_back(8'h06);
      rq.push_back(8'h07);
    end
  endtask : build

  task automatic start(input row_t r);
    no_wait_strap = r.strap;
    img = r.img;
    exp_mode = r.mode;
    ld_cnt = 0;
    build(r);
    @(posedge clk_sys);
    #1 rst_n = 1'h1;
  endtask : start

  task automatic reset_values;
    check("reset outputs", {15'h0, 2'h0, 1'h1, 2'h2, 8'hFF, 4'h0},
          {reg_wr_req, spi_rd_req, spi_manual_mode, memory_address_mode,
           spi_clock_divider, selfstart_done, eeprom_detected, load_start,
           boot_done});
  endtask : reset_values

  task automatic run(input int i);
    int n;
    start(rows[i]);
    n = 0;
    while (boot_done !== 1'h1 && n < 5000) begin
      @(posedge clk_sys);
      n++;
    end
    repeat (3) @(posedge clk_sys);
    #1;
    check("boot_done", 1, boot_done);
    check("detected", rows[i].d, eeprom_detected);
    check("mode", rows[i].mode, memory_address_mode);
    check("divider", rows[i].d ? img[63:56] : 8'hFF,
          spi_clock_divider);
    check("manual", !rows[i].d, spi_manual_mode);
    check("selfstart", rows[i].strap, selfstart_done);
    check("load pulses", rows[i].d, ld_cnt);
    check("writes left", 0, wq.size());
    check("reads left", 0, rq.size());
    $display("test %0d done", i);
    rst_n = 1'h0;
  endtask : run

  // one ack per write, gap cycles vary so prompt and late answers occur
  initial begin
    forever begin
      @(posedge clk_sys);
      #1;
      if (!rst_n || reg_wr_ack) begin
        reg_wr_ack = 1'h0;
      end else if (reg_wr_req === 1'h1) begin
        if (ack_wait == 0) begin
          reg_wr_ack = 1'h1;
          ack_wait = ack_gap;
          ack_gap = (ack_gap + 1) % 3;
        end else begin
          ack_wait--;
        end
      end
    end
  end

  always @(posedge clk_sys) begin
    if (rst_n) begin
      if (load_start === 1'h1) begin
        ld_cnt++;
      end
      if (reg_wr_req === 1'h1 && reg_wr_ack === 1'h1) begin
        check("reg write", wq.size() ? wq.pop_front() : 32'hX,
              {reg_addr, reg_wdata});
      end
      if (spi_rd_req === 1'h1 && spi_rd_valid === 1'h1) begin
        check("read addr", rq.size() ? rq.pop_front() : 8'hX,
              spi_rd_addr);
        check("probe config",
              {spi_rd_addr < 8'h06 ? 2'h2 : exp_mode, 8'hFF},
              {memory_address_mode, spi_clock_divider});
        check("self-start first", no_wait_strap, selfstart_done);
      end
    end
  end

  initial begin
    repeat (60000) @(posedge clk_sys);
    err_count++;
    give_verdict();
  end

  initial begin
    repeat (16) @(posedge clk_sys);
    #1 reset_values();
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      run(i);
    end
    // reset in the middle of self-start must restart from the first write
    start(rows[0]);
    repeat (30) @(posedge clk_sys);
    #1 rst_n = 1'h0;
    repeat (2) @(posedge clk_sys);
    #1 reset_values();
    $display("test mid reset done");
    run(0);
    give_verdict();
  end
endmodule : tb_boot_config_eeprom_detect

`default_nettype wire
